// ===== rtl/region_check_pkg.sv
// What this block does
// - Region attribute bits decide each access
// - Missing permission signals a permission fault
// - Permission 000 denies and faults everything
// - Permission 001 privileged only, unprivileged faults
// - Permission 010 faults unprivileged writes only
// - Permission 011 full access; 100 reserved
// - Permission 101 privileged reads only
// - Permission 110/111 read only for all
// - Type 000/010 low codes decode ordered/device
// - Shareable bit ignored for ordered/device/reserved
// - Type 000 cacheable is write-through normal
// - Type 001 write-back, non-cacheable or reserved
// - Type 1BB cached normal, outer/inner policy
// - Policy codes: nc, wb-alloc, wt, wb
// - Type 010 other codes are reserved
// - Cache attributes decoded, no behaviour change
// - Violation raises memory management fault
// - Fault cause recorded in status register
// - Highest-numbered matching region wins
// - Disabled subregion falls through or faults
package region_check_pkg;

  localparam int NUM_REGIONS = 8;
  localparam int REGION_IDX_W = 3;
  localparam int ADDR_W = 32;
  localparam int SIZE_W = 5;
  localparam int SRD_W = 8;

  // ************************************************************
  // Access permission codes
  // ************************************************************
  localparam logic [2:0] AP_NONE = 3'h0;
  localparam logic [2:0] AP_PRIV_RW = 3'h1;
  localparam logic [2:0] AP_USER_RO = 3'h2;
  localparam logic [2:0] AP_FULL = 3'h3;
  localparam logic [2:0] AP_RSVD = 3'h4;
  localparam logic [2:0] AP_PRIV_RO = 3'h5;
  localparam logic [2:0] AP_RO_A = 3'h6;
  localparam logic [2:0] AP_RO_B = 3'h7;

  // ************************************************************
  // Memory type and policy codes
  // ************************************************************
  localparam logic [1:0] MT_ORDERED = 2'h0;
  localparam logic [1:0] MT_DEVICE = 2'h1;
  localparam logic [1:0] MT_NORMAL = 2'h2;
  localparam logic [1:0] MT_RSVD = 2'h3;

  localparam logic [1:0] POL_NC = 2'h0;
  localparam logic [1:0] POL_WB_ALLOC = 2'h1;
  localparam logic [1:0] POL_WT = 2'h2;
  localparam logic [1:0] POL_WB = 2'h3;

  localparam logic [2:0] TEX_ZERO = 3'h0;
  localparam logic [2:0] TEX_ONE = 3'h1;
  localparam logic [2:0] TEX_TWO = 3'h2;

  // ************************************************************
  // Fault status, fault address and control registers
  // ************************************************************
  localparam logic [3:0] ADDR_FSTAT = 4'h0;
  localparam logic [3:0] ADDR_FADDR = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam int FS_IACC = 0;
  localparam int FS_DACC = 1;
  localparam int FS_NOREG = 2;
  localparam int FS_XN = 3;
  localparam int FS_VALID = 7;
  localparam logic [7:0] FSTAT_RESET = 8'h00;
  localparam logic [31:0] FADDR_RESET = 32'h0000_0000;
  localparam logic CTRL_RESET = 1'b0;

endpackage

// ===== rtl/region_attr_decode.sv
`timescale 1ns/1ns
module region_attr_decode (
  // Attribute fields
  input  wire logic [2:0] type_extension_field_in,
  input  wire logic       shareable_in,
  input  wire logic       cacheable_in,
  input  wire logic       bufferable_in,
  // Decoded attributes
  output logic [1:0]      mem_type_out,
  output logic            shared_out,
  output logic [1:0]      outer_pol_out,
  output logic [1:0]      inner_pol_out
);

  always_comb begin
    mem_type_out = region_check_pkg::MT_RSVD;
    shared_out = 1'b0;
    outer_pol_out = region_check_pkg::POL_NC;
    inner_pol_out = region_check_pkg::POL_NC;
    if (type_extension_field_in[2]) begin
      mem_type_out = region_check_pkg::MT_NORMAL;
      shared_out = shareable_in;
      outer_pol_out = type_extension_field_in[1:0];
      inner_pol_out = {cacheable_in, bufferable_in};
    end else begin
      case (type_extension_field_in)
        region_check_pkg::TEX_ZERO: begin
          if (!cacheable_in) begin
            // Shareable bit ignored here
            mem_type_out = bufferable_in ? region_check_pkg::MT_DEVICE
                                         : region_check_pkg::MT_ORDERED;
            shared_out = 1'b1;
          end else begin
            mem_type_out = region_check_pkg::MT_NORMAL;
            shared_out = shareable_in;
            outer_pol_out = region_check_pkg::POL_WT;
            inner_pol_out = region_check_pkg::POL_WT;
          end
        end
        region_check_pkg::TEX_ONE: begin
          if (cacheable_in == bufferable_in) begin
            mem_type_out = region_check_pkg::MT_NORMAL;
            shared_out = shareable_in;
            outer_pol_out = cacheable_in ? region_check_pkg::POL_WB_ALLOC
                                         : region_check_pkg::POL_NC;
            inner_pol_out = outer_pol_out;
          end
        end
        region_check_pkg::TEX_TWO: begin
          if (!cacheable_in && !bufferable_in) begin
            mem_type_out = region_check_pkg::MT_DEVICE;
          end
          // Remaining codes stay reserved
        end
        default: begin
          mem_type_out = region_check_pkg::MT_RSVD;
        end
      endcase
    end
  end

endmodule

// ===== rtl/access_perm_check.sv
`timescale 1ns/1ns
module access_perm_check (
  // Access
  input  wire logic [2:0] access_permission_field_in,
  input  wire logic       execute_never_bit_in,
  input  wire logic       priv_in,
  input  wire logic       write_in,
  input  wire logic       fetch_in,
  // Verdict
  output logic            allow_out,
  output logic            xn_fault_out
);

  logic pr;
  logic pw;
  logic ur;
  logic uw;

  always_comb begin
    pr = 1'b0;
    pw = 1'b0;
    ur = 1'b0;
    uw = 1'b0;
    case (access_permission_field_in)
      region_check_pkg::AP_NONE: begin
        pr = 1'b0;
      end
      region_check_pkg::AP_PRIV_RW: begin
        pr = 1'b1;
        pw = 1'b1;
      end
      region_check_pkg::AP_USER_RO: begin
        pr = 1'b1;
        pw = 1'b1;
        ur = 1'b1;
      end
      region_check_pkg::AP_FULL: begin
        pr = 1'b1;
        pw = 1'b1;
        ur = 1'b1;
        uw = 1'b1;
      end
      // Reserved code denies all, the safe pick
      region_check_pkg::AP_RSVD: begin
        pr = 1'b0;
      end
      region_check_pkg::AP_PRIV_RO: begin
        pr = 1'b1;
      end
      region_check_pkg::AP_RO_A, region_check_pkg::AP_RO_B: begin
        pr = 1'b1;
        ur = 1'b1;
      end
      default: begin
        pr = 1'b0;
      end
    endcase
    xn_fault_out = fetch_in && execute_never_bit_in;
    // Privilege of this access picks the rights
    allow_out = !xn_fault_out &&
                (priv_in ? (write_in ? pw : pr) : (write_in ? uw : ur));
  end

endmodule

// ===== rtl/region_permission_attribute_checker.sv
`timescale 1ns/1ns
module region_permission_attribute_checker (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Region table load
  input  wire logic        cfg_we_in,
  input  wire logic [2:0]  cfg_region_in,
  input  wire logic        cfg_enable_in,
  input  wire logic [31:0] cfg_base_in,
  input  wire logic [4:0]  cfg_size_in,
  input  wire logic [7:0]  subregion_disable_field_in,
  input  wire logic [2:0]  type_extension_field_in,
  input  wire logic        cfg_shareable_in,
  input  wire logic        cfg_cacheable_in,
  input  wire logic        cfg_bufferable_in,
  input  wire logic [2:0]  access_permission_field_in,
  input  wire logic        execute_never_bit_in,
  // Access from core
  input  wire logic        acc_valid_in,
  input  wire logic [31:0] acc_addr_in,
  input  wire logic        acc_write_in,
  input  wire logic        acc_fetch_in,
  input  wire logic        acc_priv_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_we_in,
  input  wire logic        reg_re_in,
  output logic [31:0]      reg_rdata_out,
  // Verdict
  output logic             acc_ok_out,
  output logic             mm_fault_out,
  output logic [1:0]       mem_type_out,
  output logic             shared_out,
  output logic [1:0]       outer_pol_out,
  output logic [1:0]       inner_pol_out
);

  typedef struct packed {
    logic [7:0]  en;
    logic [7:0]  xn;
    logic [7:0][31:0] base;
    logic [7:0][4:0]  size;
    logic [7:0][7:0]  subregion_disable_field;
    logic [7:0][2:0]  type_extension_field;
    logic [7:0][2:0]  ap;
    logic [7:0][2:0]  scb;
    logic        prot_en;
    logic [7:0]  fstat;
    logic [31:0] faddr;
    logic [31:0] rdata;
    logic        ok;
    logic        flt;
    logic [1:0]  mt;
    logic        sh;
    logic [1:0]  op;
    logic [1:0]  ip;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // ************************************************************
  // Region match
  // ************************************************************
  function automatic logic region_hit(input logic [31:0] a,
                                      input logic [31:0] b,
                                      input logic [4:0] sz,
                                      input logic [7:0] subregion_disable_field);
    logic [31:0] mask;
    logic [2:0]  sub;
    logic        hit;
    // Six bits so the largest size shifts to an all-zero mask
    mask = 32'hffff_ffff << ({1'b0, sz} + 6'h01);
    hit = ((a & mask) == (b & mask));
    sub = 3'h0;
    // Subregions only from 256 bytes upward
    if (sz >= 5'h7) begin
      sub = 3'((a >> (sz - 5'h2)) & 32'h7);
      hit = hit && !subregion_disable_field[sub];
    end
    return hit;
  endfunction

  logic       hit_any;
  logic [2:0] win;
  logic       allow;
  logic       xn_flt;
  logic [1:0] d_mt;
  logic       d_sh;
  logic [1:0] d_op;
  logic [1:0] d_ip;

  always_comb begin
    hit_any = 1'b0;
    win = 3'h0;
    for (int i = 0; i < region_check_pkg::NUM_REGIONS; i++) begin
      if (st_ff.en[i] && region_hit(acc_addr_in, st_ff.base[i],
                                    st_ff.size[i], st_ff.subregion_disable_field[i])) begin
        hit_any = 1'b1;
        win = 3'(i);
      end
    end
  end

  // ************************************************************
  // Decoders
  // ************************************************************
  access_perm_check u_perm (
    .access_permission_field_in (st_ff.ap[win]),
    .execute_never_bit_in       (st_ff.xn[win]),
    .priv_in                    (acc_priv_in),
    .write_in                   (acc_write_in),
    .fetch_in                   (acc_fetch_in),
    .allow_out                  (allow),
    .xn_fault_out               (xn_flt)
  );

  region_attr_decode u_attr (
    .type_extension_field_in (st_ff.type_extension_field[win]),
    .shareable_in            (st_ff.scb[win][2]),
    .cacheable_in            (st_ff.scb[win][1]),
    .bufferable_in           (st_ff.scb[win][0]),
    .mem_type_out            (d_mt),
    .shared_out              (d_sh),
    .outer_pol_out           (d_op),
    .inner_pol_out           (d_ip)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  logic bad;
  logic [7:0] cause;

  always_comb begin
    nxt_st = st_ff;
    bad = 1'b0;
    cause = 8'h00;
    if (cfg_we_in) begin
      nxt_st.en[cfg_region_in] = cfg_enable_in;
      nxt_st.base[cfg_region_in] = cfg_base_in;
      nxt_st.size[cfg_region_in] = cfg_size_in;
      nxt_st.subregion_disable_field[cfg_region_in] = subregion_disable_field_in;
      nxt_st.type_extension_field[cfg_region_in] = type_extension_field_in;
      nxt_st.scb[cfg_region_in] = {cfg_shareable_in, cfg_cacheable_in,
                                   cfg_bufferable_in};
      nxt_st.ap[cfg_region_in] = access_permission_field_in;
      nxt_st.xn[cfg_region_in] = execute_never_bit_in;
    end
    // Protection off lets everything through
    if (acc_valid_in && st_ff.prot_en) begin
      bad = !hit_any || !allow;
      cause[region_check_pkg::FS_IACC] = bad && acc_fetch_in;
      cause[region_check_pkg::FS_DACC] = bad && !acc_fetch_in;
      cause[region_check_pkg::FS_NOREG] = !hit_any;
      cause[region_check_pkg::FS_XN] = hit_any && xn_flt;
      cause[region_check_pkg::FS_VALID] = bad;
    end
    nxt_st.ok = acc_valid_in && !bad;
    nxt_st.flt = bad;
    // Attributes only reported, never steer the
    nxt_st.mt = hit_any ? d_mt : region_check_pkg::MT_ORDERED;
    nxt_st.sh = hit_any && d_sh;
    nxt_st.op = hit_any ? d_op : region_check_pkg::POL_NC;
    nxt_st.ip = hit_any ? d_ip : region_check_pkg::POL_NC;
    // Write-one-to-clear, but a new fault wins over the clear
    if (reg_we_in && reg_addr_in == region_check_pkg::ADDR_FSTAT) begin
      nxt_st.fstat = st_ff.fstat & ~reg_wdata_in[7:0];
    end
    if (reg_we_in && reg_addr_in == region_check_pkg::ADDR_CTRL) begin
      nxt_st.prot_en = reg_wdata_in[0];
    end
    if (bad) begin
      nxt_st.fstat = nxt_st.fstat | cause;
      nxt_st.faddr = acc_addr_in;
    end
    nxt_st.rdata = 32'h0000_0000;
    if (reg_re_in) begin
      case (reg_addr_in)
        region_check_pkg::ADDR_FSTAT: nxt_st.rdata = {24'h0, st_ff.fstat};
        region_check_pkg::ADDR_FADDR: nxt_st.rdata = st_ff.faddr;
        region_check_pkg::ADDR_CTRL: nxt_st.rdata = {31'h0, st_ff.prot_en};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
      st_ff.prot_en <= region_check_pkg::CTRL_RESET;
      st_ff.fstat <= region_check_pkg::FSTAT_RESET;
      st_ff.faddr <= region_check_pkg::FADDR_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out = st_ff.rdata;
  assign acc_ok_out = st_ff.ok;
  assign mm_fault_out = st_ff.flt;
  assign mem_type_out = st_ff.mt;
  assign shared_out = st_ff.sh;
  assign outer_pol_out = st_ff.op;
  assign inner_pol_out = st_ff.ip;

endmodule

// ===== testbench/perm_check_props.sv
`timescale 1ns/1ns
// ****
// Port checker
// ****
module perm_check_props (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        acc_valid_in,
  input wire logic        acc_fetch_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic        reg_re_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        acc_ok_out,
  input wire logic        mm_fault_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic st_rd;
  assign st_rd = reg_re_in && reg_addr_in == region_check_pkg::ADDR_FSTAT;
  property p_excl;
    !(acc_ok_out && mm_fault_out);
  endproperty
  a_excl: assert property (p_excl)
    else $error("ok and fault together");
  property p_one;
    acc_valid_in |=> acc_ok_out ^ mm_fault_out;
  endproperty
  a_one: assert property (p_one)
    else $error("access without one verdict");
  property p_idle;
    !acc_valid_in |=> !acc_ok_out && !mm_fault_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("verdict without access");
  property p_rd0;
    !reg_re_in |=> reg_rdata_out == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0)
    else $error("read data outside read slot");
  property p_ctrl;
    reg_re_in && reg_addr_in == region_check_pkg::ADDR_CTRL
      |=> reg_rdata_out[31:1] == 31'h0;
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control upper bits set");
  property p_fsw;
    st_rd |=> reg_rdata_out[31:8] == 24'h0;
  endproperty
  a_fsw: assert property (p_fsw)
    else $error("status upper bits set");
  property p_stat;
    mm_fault_out && st_rd |=> reg_rdata_out[region_check_pkg::FS_VALID];
  endproperty
  a_stat: assert property (p_stat)
    else $error("fault not flagged valid");
  property p_cause;
    mm_fault_out && st_rd |=> reg_rdata_out[1:0] != 2'h0;
  endproperty
  a_cause: assert property (p_cause)
    else $error("fault cause missing");
  property p_fetch;
    mm_fault_out && st_rd && $past(acc_valid_in && acc_fetch_in)
      |=> reg_rdata_out[region_check_pkg::FS_IACC];
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch fault cause missing");
  c_fault: cover property (mm_fault_out);
  c_ok: cover property (acc_ok_out);
  c_fault_rd: cover property (mm_fault_out && st_rd);
endmodule

// ===== testbench/core_access_model.sv
`timescale 1ns/1ns
// ****
// Core side: region loads and accesses
// ****
module core_access_model (
  // Clock
  input  wire logic   clk_sys_in,
  // Region table load
  output logic        cfg_we_in,
  output logic [2:0]  cfg_region_in,
  output logic        cfg_enable_in,
  output logic [31:0] cfg_base_in,
  output logic [4:0]  cfg_size_in,
  output logic [7:0]  subregion_disable_field_in,
  output logic [2:0]  type_extension_field_in,
  output logic        cfg_shareable_in,
  output logic        cfg_cacheable_in,
  output logic        cfg_bufferable_in,
  output logic [2:0]  access_permission_field_in,
  output logic        execute_never_bit_in,
  // Access
  output logic        acc_valid_in,
  output logic [31:0] acc_addr_in,
  output logic        acc_write_in,
  output logic        acc_fetch_in,
  output logic        acc_priv_in
);
  initial begin
    {cfg_we_in, cfg_region_in, cfg_enable_in, cfg_base_in} = '0;
    {cfg_size_in, subregion_disable_field_in} = '0;
    {type_extension_field_in, cfg_shareable_in} = '0;
    {cfg_cacheable_in, cfg_bufferable_in} = '0;
    {access_permission_field_in, execute_never_bit_in} = '0;
    {acc_valid_in, acc_addr_in, acc_write_in} = '0;
    {acc_fetch_in, acc_priv_in} = '0;
  end
  // Attributes as software programs them
  task automatic load(input logic [2:0] r, input logic en,
                      input logic [31:0] b, input logic [4:0] sz,
                      input logic [7:0] subregion_disable_field, input logic [5:0] at,
                      input logic [2:0] ap, input logic xn);
    @(posedge clk_sys_in);
    cfg_we_in <= 1'b1;
    cfg_region_in <= r;
    cfg_enable_in <= en;
    cfg_base_in <= b;
    cfg_size_in <= sz;
    subregion_disable_field_in <= subregion_disable_field;
    {type_extension_field_in, cfg_shareable_in} <= at[5:2];
    {cfg_cacheable_in, cfg_bufferable_in} <= at[1:0];
    access_permission_field_in <= ap;
    execute_never_bit_in <= xn;
    @(posedge clk_sys_in);
    cfg_we_in <= 1'b0;
  endtask
  task automatic access(input logic [31:0] a, input logic w, f, p);
    @(posedge clk_sys_in);
    acc_valid_in <= 1'b1;
    acc_addr_in <= a;
    acc_write_in <= w;
    acc_fetch_in <= f;
    acc_priv_in <= p;
    @(posedge clk_sys_in);
    acc_valid_in <= 1'b0;
    // Released address never repeats the last one
    acc_addr_in <= ~a;
  endtask
endmodule

// ===== testbench/region_permission_attribute_checker_tb.sv
`timescale 1ns/1ns
module region_permission_attribute_checker_tb;
  logic        clk_sys_in, rst_in, cfg_we_in, cfg_enable_in;
  logic        cfg_shareable_in, cfg_cacheable_in, cfg_bufferable_in;
  logic        execute_never_bit_in, acc_valid_in, acc_write_in;
  logic        acc_fetch_in, acc_priv_in, reg_we_in, reg_re_in;
  logic        acc_ok_out, mm_fault_out, shared_out;
  logic [1:0]  mem_type_out, outer_pol_out, inner_pol_out;
  logic [2:0]  cfg_region_in, type_extension_field_in;
  logic [2:0]  access_permission_field_in;
  logic [3:0]  reg_addr_in;
  logic [4:0]  cfg_size_in;
  logic [7:0]  subregion_disable_field_in;
  logic [31:0] cfg_base_in, acc_addr_in, reg_wdata_in, reg_rdata_out;
  int          err_count, checks_done;
  region_permission_attribute_checker u_dut (.*);
  core_access_model u_core (.*);
  // ****
  // Bus and compare tasks
  // ****
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_we_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_we_in <= 1'b0;
  endtask
  // Now set: read lands in the cycle of the last verdict
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic now);
    if (!now) @(posedge clk_sys_in);
    reg_re_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_re_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  task automatic acc(input logic [31:0] a, input logic w, f, p, e);
    u_core.access(a, w, f, p);
    #1 chk({31'h0, acc_ok_out}, {31'h0, e});
    chk({31'h0, mm_fault_out}, {31'h0, !e});
  endtask
  function automatic logic perm(input logic [2:0] ap, input logic p, w);
    case (ap)
      3'h1: return p;
      3'h2: return p | !w;
      3'h3: return 1'b1;
      3'h5: return p & !w;
      3'h6, 3'h7: return !w;
      default: return 1'b0;
    endcase
  endfunction
  // Packs care_sh, care_pol, type, shared, outer, inner
  function automatic logic [8:0] attr_exp(input logic [5:0] at);
    logic [2:0] t;
    logic       s, c, b;
    {t, s, c, b} = at;
    if (t[2]) return {2'h3, 2'h2, s, t[1:0], c, b};
    case ({t[1:0], c, b})
      4'h0: return {2'h2, 2'h0, 1'b1, 4'h0};
      4'h1: return {2'h2, 2'h1, 1'b1, 4'h0};
      4'h2, 4'h3: return {2'h3, 2'h2, s, 4'ha};
      4'h4: return {2'h3, 2'h2, s, 4'h0};
      4'h7: return {2'h3, 2'h2, s, 4'h5};
      4'h8: return {2'h2, 2'h1, 1'b0, 4'h0};
      default: return {2'h0, 2'h3, 5'h0};
    endcase
  endfunction
  // ****
  // Scenarios
  // ****
  task automatic s_reset;
    #1 chk({30'h0, acc_ok_out, mm_fault_out}, 32'h0);
    rd(4'h0, 32'h0, 1'b0);
    rd(4'h1, 32'h0, 1'b0);
    rd(4'h2, 32'h0, 1'b0);
    rd(4'hf, 32'h0, 1'b0);
    acc(32'h100, 1'b1, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic s_perm;
    wr(4'h2, 32'h1);
    for (int ap = 0; ap < 8; ap++) begin
      u_core.load(3'h0, 1'b1, 32'h0, 5'hb, 8'h0, 6'h2, ap[2:0], 1'b0);
      for (int i = 0; i < 4; i++)
        acc(32'h100, i[0], 1'b0, i[1], perm(ap[2:0], i[1], i[0]));
    end
  endtask
  task automatic s_xn;
    wr(4'h0, 32'hff);
    u_core.load(3'h0, 1'b1, 32'h0, 5'hb, 8'h0, 6'h2, 3'h3, 1'b1);
    acc(32'h200, 1'b0, 1'b1, 1'b1, 1'b0);
    rd(4'h0, 32'h89, 1'b1);
    rd(4'h1, 32'h200, 1'b0);
    acc(32'h204, 1'b1, 1'b0, 1'b0, 1'b1);
    wr(4'h0, 32'hff);
    rd(4'h0, 32'h0, 1'b0);
  endtask
  task automatic s_overlap;
    u_core.load(3'h1, 1'b1, 32'h0, 5'hb, 8'h0, 6'h2, 3'h0, 1'b0);
    acc(32'h100, 1'b0, 1'b0, 1'b1, 1'b0);
    u_core.load(3'h1, 1'b1, 32'h0, 5'hb, 8'h1, 6'h2, 3'h0, 1'b0);
    acc(32'h100, 1'b0, 1'b0, 1'b1, 1'b1);
    acc(32'h300, 1'b0, 1'b0, 1'b1, 1'b0);
    u_core.load(3'h0, 1'b0, 32'h0, 5'hb, 8'h0, 6'h2, 3'h3, 1'b0);
    wr(4'h0, 32'hff);
    acc(32'h100, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(4'h0, 32'h86, 1'b1);
  endtask
  task automatic s_attr;
    logic [8:0] e;
    for (int at = 0; at < 64; at++) begin
      if (at[5:3] == 3'h3) continue;
      u_core.load(3'h0, 1'b1, 32'h0, 5'hb, 8'h0, at[5:0], 3'h3, 1'b0);
      acc(32'h100, 1'b0, 1'b0, 1'b1, 1'b1);
      e = attr_exp(at[5:0]);
      chk({30'h0, mem_type_out}, {30'h0, e[6:5]});
      if (e[8]) chk({31'h0, shared_out}, {31'h0, e[4]});
      if (e[7]) chk({28'h0, outer_pol_out, inner_pol_out}, {28'h0, e[3:0]});
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {rst_in, reg_we_in, reg_re_in} = 3'h4;
    {reg_addr_in, reg_wdata_in} = '0;
    {err_count, checks_done} = '0;
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    s_reset;
    s_perm;
    s_xn;
    s_overlap;
    s_attr;
    finish_test;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    finish_test;
  end
endmodule
bind region_permission_attribute_checker perm_check_props u_props (.*);
